/* cell_link_group_control.sv */
// Link group control: two policy/trigger registers on APB, per-link good
// tracking, transmit hold, group gating of cell data into a buffer, and
// realign pulses. Assumes link indications and cell data arrive on clk.
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps

module cell_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH+1);

    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("cell_fifo depth must be a power of two, at least 4");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wr;
        logic [PTR_W-1:0] rd;
        logic [CNT_W-1:0] cnt;
    } fifo_state_type;

    fifo_state_type s_q;
    fifo_state_type s_d;
    logic push;
    logic pop;

    assign in_ready = (s_q.cnt != CNT_W'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_data = s_q.mem[s_q.rd];
    assign count = s_q.cnt;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr = s_q.wr + PTR_W'(1);
        end
        if (pop) begin
            s_d.rd = s_q.rd + PTR_W'(1);
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + CNT_W'(1);
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

module cell_link_group_control #(
    parameter int DEPTH = cell_link_group_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cell_link_group_pkg::ADDR_W-1:0] paddr,
    input wire logic [cell_link_group_pkg::DATA_W-1:0] pwdata,
    input wire logic [cell_link_group_pkg::STRB_W-1:0] pstrb,
    output logic pready,
    output logic [cell_link_group_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    // Receive link indications and alignment configuration
    input wire cell_link_group_pkg::link_status_type [cell_link_group_pkg::NUM_LINKS-1:0] link_status,
    input wire logic [cell_link_group_pkg::NUM_LINKS-1:0] align_en,
    // Link control outputs
    output logic [cell_link_group_pkg::NUM_LINKS-1:0] rx_link_good,
    output logic [cell_link_group_pkg::NUM_LINKS-1:0] tx_en,
    output logic [cell_link_group_pkg::NUM_LINKS-1:0] resync,
    // Cell data from links
    input wire logic in_valid,
    input wire cell_link_group_pkg::cell_word_type in_word,
    output logic in_ready,
    // Cell data to fabric
    output logic out_valid,
    output cell_link_group_pkg::cell_word_type out_word,
    input wire logic out_ready
);
    import cell_link_group_pkg::*;

    localparam int CNT_W = $clog2(DEPTH+1);
    localparam int WORD_W = $bits(cell_word_type);

    if (DEPTH < 4) begin : g_depth_check
        $error("buffer depth must be at least 4");
    end

    typedef struct packed {
        logic [7:0] policy;
        logic [7:0] trigger;
        logic pready;
        logic [DATA_W-1:0] prdata;
        logic pslverr;
        logic [NUM_LINKS-1:0] good;
        logic [NUM_LINKS-1:0] removed;
        logic [NUM_LINKS-1:0][1:0] err_cnt;
        logic [NUM_LINKS-1:0][1:0] ok_cnt;
        logic [NUM_LINKS-1:0] tx_en;
        logic [NUM_LINKS-1:0] resync;
        logic in_ready;
        logic out_valid;
        cell_word_type out_word;
    } state_type;

    state_type s_q;
    state_type s_d;

    logic hit_policy;
    logic hit_trigger;
    logic wr_take;
    logic [NUM_LINKS-1:0] rejoin_en;
    logic [NUM_LINKS-1:0] remove_en;
    logic [1:0] grp_good;
    logic forward;
    logic accept;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [WORD_W-1:0] fifo_out_data;
    logic [CNT_W-1:0] fifo_count;
    logic [7:0] trig_rise;

    assign hit_policy = (paddr == POLICY_ADDR);
    assign hit_trigger = (paddr == TRIGGER_ADDR);
    assign wr_take = psel & penable & pwrite & s_q.pready & pstrb[0];
    assign rejoin_en = {{2{s_q.policy[REJOIN_B_BIT]}}, {2{s_q.policy[REJOIN_A_BIT]}}};
    assign remove_en = {{2{s_q.policy[REMOVE_B_BIT]}}, {2{s_q.policy[REMOVE_A_BIT]}}};
    assign grp_good = {&s_q.good[3:2], &s_q.good[1:0]};
    assign forward = s_q.good[in_word.link] & (s_q.policy[PARTIAL_BIT] | grp_good[in_word.link[1]]);
    assign accept = in_valid & s_q.in_ready;
    // In partial mode, words from a link that may not forward are consumed and dropped; in grouped mode
    // in_ready stays low for an incomplete group, so a dead link stalls the shared input port
    assign fifo_in_valid = accept & forward;
    assign fifo_out_ready = ~s_q.out_valid | out_ready;

    cell_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(in_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );

    always_comb begin
        s_d = s_q;
        trig_rise = 8'h00;
        // Bus slave: one wait state, answer registered
        s_d.pready = psel & penable & ~s_q.pready;
        s_d.pslverr = 1'b0;
        s_d.prdata = '0;
        if (s_d.pready) begin
            s_d.pslverr = ~(hit_policy | hit_trigger);
            if (!pwrite && hit_policy) begin
                s_d.prdata = {24'h000000, s_q.policy};
            end else if (!pwrite && hit_trigger) begin
                s_d.prdata = {24'h000000, s_q.trigger};
            end
        end
        if (wr_take && hit_policy) begin
            s_d.policy = pwdata[7:0] & POLICY_MASK;
        end
        if (wr_take && hit_trigger) begin
            s_d.trigger = pwdata[7:0] & TRIGGER_MASK;
        end
        trig_rise = s_d.trigger & ~s_q.trigger;
        for (int i = 0; i < NUM_LINKS; i++) begin
            s_d.resync[i] = align_en[i] & (trig_rise[QUAD_BIT] | (i < 2 ? trig_rise[PAIR_A_BIT] : trig_rise[PAIR_B_BIT]));
            if (link_status[i].seq_err) begin
                s_d.ok_cnt[i] = 2'h0;
                if (s_q.err_cnt[i] != SEQ_LAST) begin
                    s_d.err_cnt[i] = s_q.err_cnt[i] + 2'h1;
                end
            end else if (link_status[i].seq_ok && s_q.ok_cnt[i] != SEQ_LAST) begin
                s_d.ok_cnt[i] = s_q.ok_cnt[i] + 2'h1;
            end
            if (remove_en[i] && !s_q.removed[i] && link_status[i].seq_err && s_q.err_cnt[i] == SEQ_LAST) begin
                s_d.removed[i] = 1'b1;
                s_d.err_cnt[i] = 2'h0;
            end else if (rejoin_en[i] && s_q.removed[i] && link_status[i].seq_ok && !link_status[i].seq_err
                         && s_q.ok_cnt[i] == SEQ_LAST) begin
                s_d.removed[i] = 1'b0;
                s_d.ok_cnt[i] = 2'h0;
                s_d.err_cnt[i] = 2'h0;
            end
            if (!link_status[i].frame_locked || s_d.removed[i]) begin
                s_d.good[i] = 1'b0;
            end else if (link_status[i].frame_boundary) begin
                s_d.good[i] = 1'b1;
            end
            s_d.tx_en[i] = ~(s_q.policy[HOLD_BIT] & s_d.removed[i]);
        end
        // Ready is registered, so leave room for the word that may land meanwhile
        s_d.in_ready = (fifo_count <= CNT_W'(DEPTH - 2)) & (s_q.policy[PARTIAL_BIT] | grp_good[in_word.link[1]]);
        if (fifo_out_valid && fifo_out_ready) begin
            s_d.out_valid = 1'b1;
            s_d.out_word = fifo_out_data;
        end else if (out_ready) begin
            s_d.out_valid = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.policy <= POLICY_RESET;
            s_q.trigger <= TRIGGER_RESET;
            s_q.tx_en <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign pready = s_q.pready;
    assign prdata = s_q.prdata;
    assign pslverr = s_q.pslverr;
    assign rx_link_good = s_q.good;
    assign tx_en = s_q.tx_en;
    assign resync = s_q.resync;
    assign in_ready = s_q.in_ready;
    assign out_valid = s_q.out_valid;
    assign out_word = s_q.out_word;

    sequence s_third_error;
        remove_en[0] && !s_q.removed[0] && link_status[0].seq_err && s_q.err_cnt[0] == 2'h2;
    endsequence
    sequence s_third_ok;
        rejoin_en[0] && s_q.removed[0] && link_status[0].seq_ok && !link_status[0].seq_err && s_q.ok_cnt[0] == 2'h2;
    endsequence

    property p_hold_blocks_tx;
        @(posedge clk) disable iff (reset)
        (s_q.policy[0] && s_q.removed[0]) ##1 s_q.removed[0] |-> !s_q.tx_en[0];
    endproperty
    a_hold_blocks_tx: assert property (p_hold_blocks_tx) else $error("transmit not held on removed link");
    property p_no_hold_tx;
        @(posedge clk) disable iff (reset)
        !s_q.policy[0] |=> (s_q.tx_en == 4'hF);
    endproperty
    a_no_hold_tx: assert property (p_no_hold_tx) else $error("transmit stopped while hold clear");
    property p_partial_pass;
        @(posedge clk) disable iff (reset)
        (accept && s_q.policy[1] && s_q.good[in_word.link]) |-> (fifo_in_valid && fifo_in_ready);
    endproperty
    a_partial_pass: assert property (p_partial_pass) else $error("healthy link word not forwarded");
    property p_group_gate;
        @(posedge clk) disable iff (reset)
        (fifo_in_valid && !s_q.policy[1]) |-> grp_good[in_word.link[1]];
    endproperty
    a_group_gate: assert property (p_group_gate) else $error("word forwarded from incomplete group");
    property p_rejoin;
        @(posedge clk) disable iff (reset)
        s_third_ok |=> !s_q.removed[0] && s_q.ok_cnt[0] == 2'h0;
    endproperty
    a_rejoin: assert property (p_rejoin) else $error("link not rejoined after three good sequences");
    property p_remove;
        @(posedge clk) disable iff (reset)
        s_third_error |=> s_q.removed[0] && !s_q.good[0];
    endproperty
    a_remove: assert property (p_remove) else $error("link not removed after three errors");
    property p_pair_b;
        @(posedge clk) disable iff (reset)
        ($rose(s_q.trigger[2]) && $past(align_en[2])) |-> s_q.resync[2] && s_q.resync[3] == $past(align_en[3]);
    endproperty
    a_pair_b: assert property (p_pair_b) else $error("pair B realign pulse missing");

    property p_pair_a;
        @(posedge clk) disable iff (reset)
        ($rose(s_q.trigger[5]) && $past(align_en[0])) |-> s_q.resync[0];
    endproperty
    a_pair_a: assert property (p_pair_a) else $error("pair A realign pulse missing");

    property p_quad;
        @(posedge clk) disable iff (reset)
        $rose(s_q.trigger[7]) |-> (s_q.resync == $past(align_en));
    endproperty
    a_quad: assert property (p_quad) else $error("quad realign pulse mismatch");

    property p_pulse_single;
        @(posedge clk) disable iff (reset)
        s_q.resync[1] |=> !s_q.resync[1];
    endproperty
    a_pulse_single: assert property (p_pulse_single) else $error("resync pulse longer than one cycle");

    property p_reset_clear;
        @(posedge clk)
        $past(reset) |-> (s_q.policy == 8'h00 && s_q.trigger == 8'h00);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("registers not clear after reset");

    property p_good_rise;
        @(posedge clk) disable iff (reset)
        $rose(s_q.good[0]) |-> $past(link_status[0].frame_boundary && link_status[0].frame_locked);
    endproperty
    a_good_rise: assert property (p_good_rise) else $error("link good rose off a frame boundary");

    property p_reserved;
        @(posedge clk) disable iff (reset)
        ((s_q.policy & 8'h24) == 8'h00) && ((s_q.trigger & 8'h5B) == 8'h00);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");
endmodule

/* cell_link_group_pkg.sv */
// Package for the link group control block: register map, field positions,
// reset values, counts and the structs carried on the block's ports.
// Assumes a single 20 MHz core clock shared with the fabric and link logic.
package cell_link_group_pkg;

    // Register bus geometry
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // Printed offsets are register indices; byte address is four times each
    localparam logic [ADDR_W-1:0] POLICY_INDEX = 24'h030A03;
    localparam logic [ADDR_W-1:0] TRIGGER_INDEX = 24'h030A04;
    localparam logic [ADDR_W-1:0] POLICY_ADDR = {POLICY_INDEX[ADDR_W-3:0], 2'h0};
    localparam logic [ADDR_W-1:0] TRIGGER_ADDR = {TRIGGER_INDEX[ADDR_W-3:0], 2'h0};

    // Error policy register fields
    localparam int HOLD_BIT = 0;
    localparam int PARTIAL_BIT = 1;
    localparam int REJOIN_A_BIT = 3;
    localparam int REMOVE_A_BIT = 4;
    localparam int REJOIN_B_BIT = 6;
    localparam int REMOVE_B_BIT = 7;
    localparam logic [7:0] POLICY_MASK = 8'hDB;
    localparam logic [7:0] POLICY_RESET = 8'h00;

    // Realign trigger register fields
    localparam int PAIR_B_BIT = 2;
    localparam int PAIR_A_BIT = 5;
    localparam int QUAD_BIT = 7;
    localparam logic [7:0] TRIGGER_MASK = 8'hA4;
    localparam logic [7:0] TRIGGER_RESET = 8'h00;

    // Links: 0 = AC, 1 = AD (block A), 2 = BC, 3 = BD (block B)
    localparam int NUM_LINKS = 4;
    localparam int LINK_W = 2;

    // Counter value reached just before the third event in a run
    localparam logic [1:0] SEQ_LAST = 2'h2;

    // Default buffer depth in cell words
    localparam int FIFO_DEPTH = 8;

    // Per-link indications from the receive framers
    typedef struct packed {
        logic frame_locked;
        logic frame_boundary;
        logic seq_ok;
        logic seq_err;
    } link_status_type;

    // One word of cell data tagged with its source link
    typedef struct packed {
        logic [LINK_W-1:0] link;
        logic [DATA_W-1:0] data;
    } cell_word_type;

endpackage

/* link_far_end.sv */
// Far-side model: receive framers, link cell source and fabric sink.
// Assumes the core clock; the bench calls its tasks right after an edge.
`timescale 1ns/100ps

module link_far_end
import cell_link_group_pkg::*;
(
    // Clock
    input wire logic clk,
    // Framer indications
    output link_status_type [NUM_LINKS-1:0] link_status,
    // Cell source
    output logic in_valid,
    output cell_word_type in_word,
    input wire logic in_ready,
    // Fabric sink
    input wire logic out_valid,
    input wire cell_word_type out_word,
    output logic out_ready,
    input wire logic stall
);
    cell_word_type got[$];

    initial begin
        link_status = '0;
        in_valid = 1'b0;
        in_word = '0;
        out_ready = 1'b0;
    end

    task lock(input int l);
        @(posedge clk);
        link_status[l].frame_locked <= 1'b1;
    endtask

    // One-cycle boundary, good-sequence or sequence-error pulse
    task ev(input int l, input logic [2:0] f);
        @(posedge clk);
        link_status[l][2:0] <= f;
        @(posedge clk);
        link_status[l][2:0] <= 3'h0;
    endtask

    // Released data shows the inverse so a stale word never looks valid
    task send(input logic [1:0] l, input logic [31:0] d, output logic acc);
        int k;
        @(posedge clk);
        in_valid <= 1'b1;
        in_word <= {l, d};
        acc = 1'b0;
        for (k = 0; k < 30 && !acc; k++) begin
            @(posedge clk);
            acc = (in_ready === 1'b1);
        end
        in_valid <= 1'b0;
        in_word <= ~{l, d};
    endtask

    // Slow sink: ready every other cycle, none while stalled
    always @(posedge clk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            got.push_back(out_word);
        end
        out_ready <= !stall && !out_ready;
    end
endmodule

/* cell_link_group_control_test.sv */
// Self-checking bench for the link group control block.
// Assumes the far-side model in link_far_end and a 20 MHz core clock.
`timescale 1ns/100ps

module cell_link_group_control_test;
    import cell_link_group_pkg::*;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, ok, acc, stall;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [STRB_W-1:0] pstrb;
    link_status_type [NUM_LINKS-1:0] link_status;
    logic [NUM_LINKS-1:0] align_en, rx_link_good, tx_en, resync;
    logic in_valid, in_ready, out_valid, out_ready;
    cell_word_type in_word, out_word;
    logic [7:0] tv [4] = '{8'h04, 8'h04, 8'h20, 8'h80};
    logic [3:0] te [4] = '{4'hC, 4'h0, 4'h3, 4'h6};
    int num_errors, checks, n, i, k;

    cell_link_group_control DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .link_status(link_status), .align_en(align_en), .rx_link_good(rx_link_good), .tx_en(tx_en),
        .resync(resync), .in_valid(in_valid), .in_word(in_word), .in_ready(in_ready),
        .out_valid(out_valid), .out_word(out_word), .out_ready(out_ready));
    link_far_end far (.clk(clk), .link_status(link_status), .in_valid(in_valid), .in_word(in_word),
        .in_ready(in_ready), .out_valid(out_valid), .out_word(out_word), .out_ready(out_ready), .stall(stall));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task check(input logic c, input string m);
        checks++;
        if (c !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task conclude;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Setup, then access until pready; request held till that edge
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int j;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        j = 0;
        do begin
            @(posedge clk);
            j++;
        end while (pready !== 1'b1 && j < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            conclude;
        end
        rd = prdata;
        ok = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string m);
        apb(1'b0, a, 8'h00);
        check(rd === {24'h000000, e} && ok === 1'b0, m);
    endtask

    // Pulse must appear on exactly the expected channels, for one cycle
    task rsy(input logic [3:0] e);
        logic [3:0] seen;
        int c;
        seen = 4'h0;
        c = 0;
        for (int j = 0; j < 3; j++) begin
            #1;
            seen = seen | resync;
            if (resync !== 4'h0) c++;
            @(posedge clk);
        end
        check(seen === e && (e == 4'h0 || c == 1), "resync pulse wrong");
    endtask

    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        align_en = 4'hF;
        stall = 1'b0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rdchk(POLICY_ADDR, 8'h00, "policy reset value");
        rdchk(TRIGGER_ADDR, 8'h00, "trigger reset value");
        apb(1'b0, 24'h000000, 8'h00);
        check(ok === 1'b1 && rd === 32'h00000000, "unmapped read not refused");
        apb(1'b1, POLICY_ADDR, 8'hFF);
        rdchk(POLICY_ADDR, POLICY_MASK, "policy reserved bits");
        apb(1'b1, TRIGGER_ADDR, 8'h5B);
        rdchk(TRIGGER_ADDR, 8'h00, "trigger reserved bits");
        apb(1'b1, POLICY_ADDR, 8'h00);
        // Low byte strobe off: the write must not land
        pstrb <= 4'hE;
        apb(1'b1, POLICY_ADDR, 8'hFF);
        pstrb <= 4'hF;
        rdchk(POLICY_ADDR, 8'h00, "strobe-masked write");
        // Second entry rewrites a set bit, so it must stay quiet
        for (i = 0; i < 4; i++) begin
            if (i != 1) apb(1'b1, TRIGGER_ADDR, 8'h00);
            align_en <= (i == 3) ? 4'h6 : 4'hF;
            apb(1'b1, TRIGGER_ADDR, tv[i]);
            rsy(te[i]);
        end
        for (i = 0; i < NUM_LINKS; i++) begin
            far.lock(i);
            settle;
            check(rx_link_good[i] === 1'b0, "good before boundary");
            far.ev(i, 3'b100);
            settle;
            check(rx_link_good[i] === 1'b1, "good after boundary");
        end
        stall <= 1'b1;
        n = 0;
        acc = 1'b1;
        while (acc && n < 16) begin
            far.send(n[1:0], 32'hC0DE0000 + n, acc);
            if (acc) n++;
        end
        // Output register plus DEPTH-1 buffered words before refusal
        check(n == FIFO_DEPTH, "buffer never refused");
        stall <= 1'b0;
        for (k = 0; k < 400 && far.got.size() < n; k++) @(posedge clk);
        check(far.got.size() == n, "drained word count");
        for (i = 0; i < n && i < far.got.size(); i++) check(far.got[i].data === 32'hC0DE0000 + i, "word order");
        apb(1'b1, POLICY_ADDR, 8'h11);
        for (i = 0; i < 3; i++) begin
            far.ev(0, 3'b001);
            far.ev(2, 3'b001);
        end
        settle;
        check(rx_link_good === 4'hE && tx_en === 4'hE, "removal and hold");
        far.got.delete();
        far.send(2'h1, 32'h0000005A, acc);
        repeat (12) @(posedge clk);
        check(far.got.size() == 0, "grouped mode forwarded");
        apb(1'b1, POLICY_ADDR, 8'h13);
        far.send(2'h1, 32'h000000A5, acc);
        for (k = 0; k < 40 && far.got.size() == 0; k++) @(posedge clk);
        check(far.got.size() == 1 && far.got[0].data === 32'h000000A5, "partial mode blocked");
        apb(1'b1, POLICY_ADDR, 8'h80);
        for (i = 0; i < 3; i++) far.ev(3, 3'b001);
        settle;
        check(rx_link_good === 4'h6 && tx_en === 4'hF, "transmit without hold");
        apb(1'b1, POLICY_ADDR, 8'h88);
        for (i = 0; i < 3; i++) far.ev(0, 3'b010);
        settle;
        check(rx_link_good[0] === 1'b0, "rejoin before boundary");
        far.ev(0, 3'b100);
        settle;
        check(rx_link_good[0] === 1'b1, "rejoin failed");
        conclude;
    end
endmodule
